// [inc/cic_pkg.sv]
// Shared constants for the controller initialisation ends
// Behaviour
// - Strap high selects demultiplexed host bus
// - Strap low: PCI, port defaults local bus
// - Slave only until action request
// - Host configures before setting action request
// - Byte order bit chosen first
// - Burst bit acts only in demux mode
// - Two bits choose DMA priority scheme
// - Port fields select four pin uses
// - Host sets queue bases and lengths
// - Host reserves ring buffers before activation
// - Control mode zero checks hold bit
// - Host sets FIFO thresholds before activation
// - Host loads first descriptor addresses
// - Host sets hold in last descriptor
// - Host writes last descriptor addresses
// - Channel config: masks and DMA resets
// - Power switching keeps registers and state
// - Powered-down channel: no clocks, no serial interrupts; DMA interrupts still pass
// - Host configures serial channel in order
// - Local bus serves micro and peripherals
// - Host initialises selected peripheral registers
// - Reset: powered down, HDLC, NRZ
package cic_pkg;
  localparam int NCH = 4;
  localparam int AW = 8;
  localparam int DW = 32;
  // Register byte addresses
  localparam logic [7:0] ADDR_GMODE = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_RXQ = 8'h10;
  localparam logic [7:0] ADDR_TXQ = 8'h20;
  localparam logic [7:0] ADDR_CFGQ = 8'h30;
  localparam logic [7:0] ADDR_PERQ = 8'h34;
  localparam logic [7:0] ADDR_QLENA = 8'h38;
  localparam logic [7:0] ADDR_QLENB = 8'h3C;
  localparam logic [7:0] ADDR_FIFO = 8'h40;
  localparam logic [7:0] ADDR_FRXD = 8'h50;
  localparam logic [7:0] ADDR_FTXD = 8'h60;
  localparam logic [7:0] ADDR_LRXD = 8'h70;
  localparam logic [7:0] ADDR_LTXD = 8'h80;
  localparam logic [7:0] ADDR_CHCFG = 8'h90;
  localparam logic [7:0] ADDR_SCFG0 = 8'hA0;
  localparam logic [7:0] ADDR_SCFG1 = 8'hB0;
  localparam logic [7:0] ADDR_SCFG2 = 8'hC0;
  localparam logic [7:0] ADDR_SMASK = 8'hD0;
  localparam logic [7:0] ADDR_PERIPH = 8'hE0;
  // Global mode fields
  localparam int GM_ORDER = 0;
  localparam int GM_BURST = 1;
  localparam int GM_PRIO = 2;
  localparam int GM_CHORD = 3;
  localparam int GM_PCFG = 4;
  localparam int GM_LBMODE = 6;
  localparam int GM_CMODE = 7;
  // Command, status and channel config fields
  localparam int CMD_AR = 0;
  localparam int ST_ACK = 0;
  localparam int ST_DEMUX = 1;
  localparam int ST_MASTER = 2;
  localparam int CC_FRM = 0;
  localparam int CC_ERR = 1;
  localparam int CC_TERR = 2;
  localparam int CC_RXRST = 3;
  localparam int CC_TXRST = 4;
  // Serial config 0 fields
  localparam int S0_PU = 0;
  localparam int S0_PROTO = 1;
  localparam int S0_CODE = 3;
  localparam int S0_CLK = 5;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
  localparam logic [1:0] PROTO_HDLC = 2'h0;
  localparam logic [1:0] CODE_NRZ = 2'h0;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // Port pin uses
  typedef enum logic [1:0] {
    CIC_LB_ONLY = 2'h0, CIC_GP_LB = 2'h1, CIC_GP_SS_LB = 2'h2, CIC_GP16_LB = 2'h3
  } cic_port_use_t;
endpackage

// [inc/cic_bus_if.sv]
// Register access link between host and controller
`timescale 1ns/1ps
interface cic_bus_if;
  import cic_pkg::*;
  logic req;
  logic wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wrData;
  logic [DW-1:0] rdData;
  logic ack;
  modport host (output req, output wr, output addr, output wrData, input rdData, input ack);
  modport dev (input req, input wr, input addr, input wrData, output rdData, output ack);
endinterface

// [logic/cic_device.sv]
// Controller end: registers, strap capture, activation and channel gating
`timescale 1ns/1ps
module cic_device (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Host link
  cic_bus_if.dev bus,
  // Strap pin
  input wire logic busModeStrap,
  // Channel events and DMA hooks
  input wire logic [cic_pkg::NCH-1:0] serialEvent,
  input wire logic [3*cic_pkg::NCH-1:0] dmaEvent,
  input wire logic descFetched,
  input wire logic descHold,
  input wire logic [cic_pkg::DW-1:0] memDataIn,
  // Status outputs
  output logic demuxMode,
  output logic busMaster,
  output logic burstActive,
  output logic [1:0] prioScheme,
  output cic_pkg::cic_port_use_t portUse,
  output logic localBusMuxed,
  output logic localBusEn,
  output logic branchNext,
  output logic descStop,
  output logic [cic_pkg::DW-1:0] memDataOut,
  output logic [cic_pkg::NCH-1:0] chanClkEn,
  output logic [cic_pkg::NCH-1:0] serialIrq,
  output logic [cic_pkg::NCH-1:0] dmaIrq,
  output logic [cic_pkg::NCH-1:0] rxDmaReset,
  output logic [cic_pkg::NCH-1:0] txDmaReset
);
  import cic_pkg::*;

  function automatic logic [31:0] swapBytes(input logic [31:0] d, input logic big);
    swapBytes = big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction

  logic [31:0] regs [0:63];
  logic [1:0] strapSync;
  logic [1:0] settleCnt;
  logic strapTaken;
  logic actAck;
  logic ackPend;
  logic ackQ;
  logic [31:0] rdQ;
  logic [NCH-1:0] rxRstQ;
  logic [NCH-1:0] txRstQ;
  logic [31:0] next_rd;
  logic [31:0] memQ;

  wire take = bus.req & ~ackQ;
  wire doWr = take & bus.wr;
  wire [5:0] idx = bus.addr[7:2];
  wire isCmd = bus.addr == ADDR_CMD;
  wire isStat = bus.addr == ADDR_STAT;
  wire arWrite = doWr & isCmd & bus.wrData[CMD_AR];
  wire ackClr = doWr & isStat & bus.wrData[ST_ACK];
  wire [31:0] gmode = regs[ADDR_GMODE[7:2]];
  wire [31:0] statWord = {29'h0000_0000, busMaster, demuxMode, actAck};

  // Strap is synchronised, then caught once after reset release
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      strapSync <= 2'h0;
      settleCnt <= 2'h0;
      strapTaken <= 1'b0;
      demuxMode <= 1'b0;
    end else begin
      strapSync <= {strapSync[0], busModeStrap};
      if (settleCnt != STRAP_SETTLE) begin
        settleCnt <= settleCnt + 2'h1;
      end else if (!strapTaken) begin
        strapTaken <= 1'b1;
        demuxMode <= strapSync[1];
      end
    end
  end

  // Register store; zero reset gives powered down, HDLC, NRZ, local bus only
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 64; i++) begin
        regs[i] <= RESET_VAL;
      end
    end else if (doWr && !isCmd && !isStat) begin
      regs[idx] <= bus.wrData;
    end
  end

  always_comb begin
    next_rd = regs[idx];
    if (isStat) begin
      next_rd = statWord;
    end else if (isCmd) begin
      next_rd = RESET_VAL;
    end
  end

  // Bus slave answer: one-cycle ack the edge after a request is taken
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ackQ <= 1'b0;
      rdQ <= RESET_VAL;
    end else begin
      ackQ <= take;
      if (take && !bus.wr) begin
        rdQ <= next_rd;
      end
    end
  end
  assign bus.ack = ackQ;
  assign bus.rdData = rdQ;

  // Activation: master only after action request; ack set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      busMaster <= 1'b0;
      ackPend <= 1'b0;
      actAck <= 1'b0;
    end else begin
      ackPend <= arWrite;
      if (arWrite) begin
        busMaster <= 1'b1;
      end
      if (ackPend) begin
        actAck <= 1'b1;
      end else if (ackClr) begin
        actAck <= 1'b0;
      end
    end
  end

  // DMA reset commands from channel config are one-cycle pulses
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rxRstQ <= '0;
      txRstQ <= '0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        rxRstQ[n] <= doWr && idx == ADDR_CHCFG[7:2] + 6'(n) && bus.wrData[CC_RXRST];
        txRstQ[n] <= doWr && idx == ADDR_CHCFG[7:2] + 6'(n) && bus.wrData[CC_TXRST];
      end
    end
  end
  assign rxDmaReset = rxRstQ;
  assign txDmaReset = txRstQ;

  // Global mode decode
  assign burstActive = gmode[GM_BURST] & demuxMode;
  assign prioScheme = {gmode[GM_CHORD], gmode[GM_PRIO]};
  assign portUse = cic_port_use_t'(gmode[GM_PCFG +: 2]);
  assign localBusMuxed = gmode[GM_LBMODE];
  assign localBusEn = ~demuxMode;
  wire [31:0] memSwapped = swapBytes(memDataIn, gmode[GM_ORDER]);

  // Byte-ordered memory data leaves from a register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      memQ <= RESET_VAL;
    end else begin
      memQ <= memSwapped;
    end
  end
  assign memDataOut = memQ;

  // Descriptor branching
  wire fetchOk = descFetched & busMaster;
  assign branchNext = fetchOk & (gmode[GM_CMODE] | ~descHold);
  assign descStop = fetchOk & ~gmode[GM_CMODE] & descHold;

  // Per-channel clock gating and interrupt forwarding
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gch
      wire [31:0] cfg0 = regs[ADDR_SCFG0[7:2] + 6'(g)];
      wire [31:0] chCfg = regs[ADDR_CHCFG[7:2] + 6'(g)];
      wire [31:0] sMask = regs[ADDR_SMASK[7:2] + 6'(g)];
      wire [2:0] evt = dmaEvent[3*g +: 3];
      wire [2:0] evtMask = {chCfg[CC_TERR], chCfg[CC_ERR], chCfg[CC_FRM]};
      assign chanClkEn[g] = cfg0[S0_PU];
      assign serialIrq[g] = serialEvent[g] & cfg0[S0_PU] & ~sMask[0];
      assign dmaIrq[g] = |(evt & ~evtMask);
    end
  endgenerate
endmodule

// [logic/cic_host.sv]
// Host end: ordered configuration writes, then action request and ack poll
`timescale 1ns/1ps
module cic_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Controller link
  cic_bus_if.host bus,
  // User control
  input wire logic start,
  output logic busy,
  output logic done,
  // Configuration values
  input wire logic [7:0] globalMode,
  input wire logic [31:0] memBase,
  input wire logic [31:0] queueLen,
  input wire logic [31:0] fifoCfg,
  input wire logic [31:0] chanCfg,
  input wire logic [31:0] serialCfg0,
  input wire logic [31:0] serialCfg1,
  input wire logic [31:0] serialCfg2,
  input wire logic [31:0] serialMask,
  input wire logic [31:0] periphSetup
);
  import cic_pkg::*;

  localparam logic [5:0] NSTEP = 6'd53;
  localparam logic [31:0] CLK_ONLY = 32'h0000_00E0;
  localparam logic [31:0] PROTO_ADD = 32'h0000_0006;
  localparam logic [31:0] CODE_ADD = 32'h0000_0018;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_WRITE = 2'h1, H_POLL = 2'h3, H_DONE = 2'h2
  } cic_host_state_t;

  function automatic logic [31:0] memAt(input logic [31:0] b, input logic [5:0] k);
    memAt = b + {20'h0_0000, k, 6'h00};
  endfunction

  // Step table: global mode, queues, descriptors, channels, serial, periph, AR
  function automatic logic [39:0] step(input logic [5:0] s);
    logic [5:0] c;
    logic [1:0] n;
    logic [31:0] c0;
    c = s - 6'd35;
    n = c[1:0];
    c0 = serialCfg0 & ~32'h0000_0001;
    step = {ADDR_CMD, 32'h0000_0001};
    if (s == 6'd0) step = {ADDR_GMODE, 24'h00_0000, 7'h00, globalMode[GM_ORDER]};
    else if (s == 6'd1) step = {ADDR_GMODE, 24'h00_0000, globalMode};
    else if (s < 6'd10) step = {ADDR_RXQ + {s - 6'd2, 2'h0}, memAt(memBase, s)};
    else if (s == 6'd10) step = {ADDR_CFGQ, memAt(memBase, s)};
    else if (s == 6'd11) step = {ADDR_PERQ, memAt(memBase, s)};
    else if (s == 6'd12) step = {ADDR_QLENA, queueLen};
    else if (s == 6'd13) step = {ADDR_QLENB, queueLen};
    else if (s == 6'd14) step = {ADDR_FIFO, fifoCfg};
    else if (s < 6'd23) step = {ADDR_FRXD + {s - 6'd15, 2'h0}, memAt(memBase, s)};
    else if (s < 6'd31) step = {ADDR_LRXD + {s - 6'd23, 2'h0}, memAt(memBase, s)};
    else if (s < 6'd35) step = {ADDR_CHCFG + {s - 6'd31, 2'h0}, chanCfg};
    else if (s < 6'd39) step = {ADDR_SCFG0 + {n, 2'h0}, c0 & CLK_ONLY};
    else if (s < 6'd43) step = {ADDR_SCFG0 + {n, 2'h0}, c0 & (CLK_ONLY | PROTO_ADD)};
    else if (s < 6'd47) step = {ADDR_SCFG1 + {n, 2'h0}, serialCfg1};
    else if (s < 6'd51) step = {ADDR_SCFG2 + {n, 2'h0}, serialCfg2};
    else if (s == 6'd51) step = {ADDR_SMASK, serialMask};
    else if (s == 6'd52) step = {ADDR_PERIPH, periphSetup};
  endfunction

  cic_host_state_t state;
  cic_host_state_t next_state;
  logic [5:0] stepIdx;
  logic [1:0] chIdx;
  logic [1:0] phase;
  logic reqQ;
  logic wrQ;
  logic [7:0] addrQ;
  logic [31:0] dataQ;

  wire [39:0] cur = step(stepIdx);
  wire lastStep = stepIdx == NSTEP;
  wire acked = bus.ack & reqQ;
  wire arSeen = acked & ~wrQ & bus.rdData[ST_ACK];

  always_comb begin
    next_state = state;
    case (state)
      H_IDLE: if (start) next_state = H_WRITE;
      H_WRITE: if (acked && lastStep) next_state = H_POLL;
      H_POLL: if (arSeen) next_state = H_DONE;
      H_DONE: next_state = H_DONE;
      default: next_state = H_IDLE;
    endcase
  end

  // Serial config 0 also gets coding added in its own step before cfg1
  wire [31:0] cfg0Code = (serialCfg0 & ~32'h0000_0001) & (CLK_ONLY | PROTO_ADD | CODE_ADD);
  wire codeStep = stepIdx >= 6'd43 && stepIdx < 6'd47 && phase == 2'h0;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= H_IDLE;
      stepIdx <= 6'h00;
      chIdx <= 2'h0;
      phase <= 2'h0;
      reqQ <= 1'b0;
      wrQ <= 1'b0;
      addrQ <= 8'h00;
      dataQ <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (acked) begin
        reqQ <= 1'b0;
        if (state == H_WRITE) begin
          if (codeStep) phase <= 2'h1;
          else begin
            phase <= 2'h0;
            stepIdx <= stepIdx + 6'h01;
          end
        end
      end else if (!reqQ && state == H_WRITE) begin
        reqQ <= 1'b1;
        wrQ <= 1'b1;
        addrQ <= codeStep ? ADDR_SCFG0 + {stepIdx[1:0] - 2'h3, 2'h0} : cur[39:32];
        dataQ <= codeStep ? cfg0Code : cur[31:0];
      end else if (!reqQ && state == H_POLL) begin
        reqQ <= 1'b1;
        wrQ <= 1'b0;
        addrQ <= ADDR_STAT;
        dataQ <= 32'h0000_0000;
      end
    end
  end

  assign bus.req = reqQ;
  assign bus.wr = wrQ;
  assign bus.addr = addrQ;
  assign bus.wrData = dataQ;
  assign busy = state == H_WRITE || state == H_POLL;
  assign done = state == H_DONE;
endmodule

// [tb/cic_init_chk.sv]
// Checker for the host to controller register link
`timescale 1ns/1ps
module cic_init_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Link signals
  input wire logic req,
  input wire logic wr,
  input wire logic [cic_pkg::AW-1:0] addr,
  input wire logic [cic_pkg::DW-1:0] wrData,
  input wire logic [cic_pkg::DW-1:0] rdData,
  input wire logic ack
);
  import cic_pkg::*;
  logic firstDone;
  logic maskSeen;
  logic cfg0Seen;
  wire wrDone = ack && wr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      firstDone <= 1'b0;
      maskSeen <= 1'b0;
      cfg0Seen <= 1'b0;
    end else begin
      firstDone <= firstDone | wrDone;
      maskSeen <= maskSeen | (wrDone && addr[7:4] == 4'hD);
      cfg0Seen <= cfg0Seen | (wrDone && addr[7:4] == 4'hA);
    end
  end
  sequence s_taken;
    req && !ack;
  endsequence
  sequence s_answer;
    ##1 ack ##1 !ack && !req;
  endsequence
  property p_ack_resp;
    s_taken |-> s_answer;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack not one cycle after request");
  property p_ack_cause;
    ack |-> $past(req && !ack);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");
  property p_req_hold;
    req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wrData);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_req_drop;
    ack |=> !req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held after ack");
  property p_rd_hold;
    !ack |-> $stable(rdData);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without ack");
  property p_first_order;
    req && wr && !firstDone |-> addr == ADDR_GMODE && wrData[31:1] == 31'h0;
  endproperty
  a_first_order: assert property (p_first_order) else $error("first write not byte order");
  property p_ar_last;
    req && wr && addr == ADDR_CMD |-> maskSeen;
  endproperty
  a_ar_last: assert property (p_ar_last) else $error("action request before setup");
  property p_mask_late;
    req && wr && addr[7:4] == 4'hD |-> cfg0Seen;
  endproperty
  a_mask_late: assert property (p_mask_late) else $error("mask written before channel mode");
  c_act: cover property (req && wr && addr == ADDR_CMD);
endmodule

// [tb/controller_init_sequence_test.sv]
// Bench joining host and controller ends across the register link
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, a, b); end end
module controller_init_sequence_test;
  import cic_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic busModeStrap = 1'b0;
  logic start = 1'b0;
  logic [7:0] gMode = 8'h6B;
  logic [31:0] cfgA = 32'h0001_0404;
  logic [31:0] cfgB = 32'h0000_0010;
  logic [31:0] sCfg0 = 32'h0000_000A;
  logic [3:0] serialEvent = 4'hF;
  logic [11:0] dmaEvent = 12'hFFF;
  logic descFetched = 1'b0;
  logic descHold = 1'b0;
  logic [31:0] memDataIn = 32'h1122_3344;
  logic busy, done, demuxMode, busMaster, burstActive, localBusMuxed, localBusEn;
  logic branchNext, descStop;
  logic [1:0] prioScheme;
  cic_port_use_t portUse;
  logic [31:0] memDataOut;
  logic [3:0] chanClkEn, serialIrq, dmaIrq, rxDmaReset, txDmaReset;
  int n_mismatch = 0;
  int n_checks = 0;
  int rxPulses = 0;
  int txPulses = 0;
  always @(negedge ref_clk) begin
    rxPulses <= rxPulses + $countones(rxDmaReset);
    txPulses <= txPulses + $countones(txDmaReset);
  end
  cic_bus_if cic_bus_if_inst ();
  always #20 ref_clk = ~ref_clk;
  cic_host cic_host_inst (.ref_clk(ref_clk), .nrst(nrst), .bus(cic_bus_if_inst.host),
    .start(start), .busy(busy), .done(done), .globalMode(gMode), .memBase(cfgA),
    .queueLen(cfgB), .fifoCfg(cfgA), .chanCfg(32'h0000_000D), .serialCfg0(sCfg0),
    .serialCfg1(cfgA), .serialCfg2(cfgB), .serialMask(32'h0000_0000), .periphSetup(cfgB));
  cic_device cic_device_inst (.ref_clk(ref_clk), .nrst(nrst), .bus(cic_bus_if_inst.dev),
    .busModeStrap(busModeStrap), .serialEvent(serialEvent), .dmaEvent(dmaEvent),
    .descFetched(descFetched), .descHold(descHold), .memDataIn(memDataIn),
    .demuxMode(demuxMode), .busMaster(busMaster), .burstActive(burstActive),
    .prioScheme(prioScheme), .portUse(portUse), .localBusMuxed(localBusMuxed),
    .localBusEn(localBusEn), .branchNext(branchNext), .descStop(descStop),
    .memDataOut(memDataOut), .chanClkEn(chanClkEn), .serialIrq(serialIrq), .dmaIrq(dmaIrq),
    .rxDmaReset(rxDmaReset), .txDmaReset(txDmaReset));
  cic_init_chk cic_init_chk_inst (.ref_clk(ref_clk), .nrst(nrst), .req(cic_bus_if_inst.req),
    .wr(cic_bus_if_inst.wr), .addr(cic_bus_if_inst.addr), .wrData(cic_bus_if_inst.wrData),
    .rdData(cic_bus_if_inst.rdData), .ack(cic_bus_if_inst.ack));
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task do_reset(input logic strap);
    @(negedge ref_clk) nrst = 1'b0;
    busModeStrap = strap;
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
  endtask
  task run_host;
    int i;
    @(negedge ref_clk) start = 1'b1;
    @(negedge ref_clk) start = 1'b0;
    `CHK(busy, 1'b1)
    `CHK(busMaster, 1'b0)
    for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge ref_clk);
    `CHK(done, 1'b1)
    `CHK(busMaster, 1'b1)
  endtask
  task t_reset_state;
    `CHK(busMaster, 1'b0)
    `CHK(chanClkEn, 4'h0)
    `CHK(serialIrq, 4'h0)
    `CHK(portUse, CIC_LB_ONLY)
    repeat (6) @(negedge ref_clk);
    `CHK(demuxMode, 1'b0)
    `CHK(localBusEn, 1'b1)
    `CHK(memDataOut, 32'h1122_3344)
  endtask
  task t_pci_config;
    run_host;
    `CHK(burstActive, 1'b0)
    `CHK(prioScheme, 2'h2)
    `CHK(portUse, CIC_GP_SS_LB)
    `CHK(localBusMuxed, 1'b1)
    `CHK(memDataOut, 32'h4433_2211)
    `CHK(chanClkEn, 4'h0)
    `CHK(serialIrq, 4'h0)
    `CHK(rxPulses, 4)
    `CHK(txPulses, 0)
  endtask
  task t_desc(input logic hold, input logic expBranch);
    @(negedge ref_clk) descHold = hold;
    descFetched = 1'b1;
    #1;
    `CHK(branchNext, expBranch)
    `CHK(descStop, ~expBranch)
    @(negedge ref_clk) descFetched = 1'b0;
  endtask
  task t_irq;
    @(negedge ref_clk) dmaEvent = 12'hB6D;
    #1;
    `CHK(dmaIrq, 4'h0)
    @(negedge ref_clk);
    dmaEvent = 12'hFFF;
    #1;
    `CHK(dmaIrq, 4'hF)
  endtask
  task t_demux;
    @(negedge ref_clk) gMode = 8'h82;
    do_reset(1'b1);
    repeat (6) @(negedge ref_clk);
    `CHK(demuxMode, 1'b1)
    `CHK(localBusEn, 1'b0)
    run_host;
    `CHK(burstActive, 1'b1)
    `CHK(prioScheme, 2'h0)
    `CHK(portUse, CIC_LB_ONLY)
    `CHK(memDataOut, 32'h1122_3344)
    t_desc(1'b1, 1'b1);
  endtask
  initial begin
    do_reset(1'b0);
    t_reset_state;
    t_pci_config;
    t_desc(1'b0, 1'b1);
    t_desc(1'b1, 1'b0);
    t_irq;
    t_demux;
    summarize;
  end
  initial begin
    #2000000;
    n_mismatch++;
    summarize;
  end
endmodule
